// >>> logic/pc_sequencer_flag_banks.sv
// Program counter sequencer, dual flag banks and control collector
// Function
// - Program fetch address is a 13-bit counter covering 8192 bytes.
// - After a fetch the counter increments and keeps the new value.
// - Load target on jump, call or irq, pop on ret or return_from_interrupt, else plus one on a fetch and hold without one.
// - Two flag banks, each with carry, zero and sign.
// - Interrupt or call start moves flag access to the irq bank.
// - Return from interrupt restores normal bank if it was normal before.
// - Bank switching happens by itself on irq, call, ret, return_from_interrupt.
// - Switching never clears flags; each bank keeps its values.
// - Only the active bank is visible and writable.
// - Carry set on arithmetic overflow, cleared on an arithmetic result without overflow, held on other cycles.
// - Sign set on arithmetic underflow, cleared on an arithmetic result without underflow, held on other cycles.
// - Instructions last from 6 to 26 clock cycles.
// - Arbiter enables exactly one of five decode groups by type.
// - Never more than one decode group active at once.
// - Collector merges group controls into one control set.
// - On irq or call, push the program counter before loading.
module pc_sequencer_flag_banks (
   input  wire logic                     SYS_CLK_IN,
   input  wire logic                     ARST_N_IN,
   input  wire logic                     FETCH_IN,
   input  wire seq_pkg::flow_e           FLOW_IN,
   input  wire logic [seq_pkg::PC_W-1:0] TARGET_IN,
   input  wire logic [seq_pkg::PC_W-1:0] POP_PC_IN,
   input  wire logic                     DECODE_VALID_IN,
   input  wire seq_pkg::group_e          DECODE_GROUP_IN,
   input  wire logic [seq_pkg::CYC_W-1:0] DECODE_CYCLES_IN,
   input  wire seq_pkg::alu_res_s        ALU_RES_IN,
   output logic      [seq_pkg::PC_W-1:0] PC_OUT,
   output logic                          PUSH_OUT,
   output logic      [seq_pkg::PC_W-1:0] PUSH_PC_OUT,
   output seq_pkg::flags_s               FLAGS_OUT,
   output logic                          IRQ_BANK_OUT,
   output seq_pkg::ctrl_s                CTRL_OUT
);
   // Nesting depth for bank return: depth 0 is normal mode
   localparam int DEPTH_W = 7;

   typedef struct packed {
      logic [seq_pkg::PC_W-1:0] pc;
      logic                     push;
      logic [seq_pkg::PC_W-1:0] push_pc;
      seq_pkg::flags_s          normal;
      seq_pkg::flags_s          irq;
      logic                     irq_bank;
      logic [DEPTH_W-1:0]       depth;
      seq_pkg::flags_s          flags;
      seq_pkg::ctrl_s           ctrl;
   } seq_s;

   seq_s st_r;
   seq_s st_nxt;

   logic [seq_pkg::GROUPS-1:0] grp_active;
   logic                       grp_done;
   seq_pkg::flags_s            upd;
   seq_pkg::flags_s            cur;

   // Arbiter grants one group at a time
   group_arbiter #(
      .GROUPS (seq_pkg::GROUPS)
   ) u_arb (
      .clk    (SYS_CLK_IN),
      .arst_n (ARST_N_IN),
      .start  (DECODE_VALID_IN),
      .group  (DECODE_GROUP_IN),
      .cycles (DECODE_CYCLES_IN),
      .active (grp_active),
      .done   (grp_done)
   );

   // Flag update from the current ALU result on the active bank
   always_comb begin
      cur = st_r.irq_bank ? st_r.irq : st_r.normal;
      upd = cur;
      if (ALU_RES_IN.valid) begin
         upd.zero = ALU_RES_IN.is_zero;
         if (ALU_RES_IN.arith) begin
            upd.carry = ALU_RES_IN.overflow;
            upd.sign  = ALU_RES_IN.underflow;
         end
      end
   end

   // Next state: program counter, stack push, bank selection
   always_comb begin
      st_nxt = st_r;
      st_nxt.push = 1'b0;
      // Update only the bank in use; other bank untouched
      if (st_r.irq_bank)
         st_nxt.irq = upd;
      else
         st_nxt.normal = upd;
      unique case (FLOW_IN)
         seq_pkg::FLOW_JUMP: begin
            st_nxt.pc = TARGET_IN;
         end
         seq_pkg::FLOW_CALL,
         seq_pkg::FLOW_IRQ: begin
            st_nxt.push = 1'b1;
            st_nxt.push_pc = st_r.pc;
            st_nxt.pc = TARGET_IN;
            st_nxt.irq_bank = 1'b1;
            if (st_r.depth != '1)
               st_nxt.depth = st_r.depth + 7'h01;
         end
         seq_pkg::FLOW_RET,
         seq_pkg::FLOW_RETURN_FROM_INTERRUPT: begin
            st_nxt.pc = POP_PC_IN;
            if (st_r.depth != '0)
               st_nxt.depth = st_r.depth - 7'h01;
            // Back to normal flags only when leaving the outermost level
            if (st_r.depth <= 7'h01)
               st_nxt.irq_bank = 1'b0;
         end
         default: begin
            if (FETCH_IN)
               st_nxt.pc = st_r.pc + seq_pkg::PC_STEP;
         end
      endcase
      // Visible flags registered from the bank selected next
      st_nxt.flags = st_nxt.irq_bank ? st_nxt.irq : st_nxt.normal;
      // Collector: one merged control set
      st_nxt.ctrl.group_onehot = grp_active;
      st_nxt.ctrl.busy = |grp_active;
      st_nxt.ctrl.done = grp_done;
   end

   always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         st_r <= '0;
         st_r.pc <= seq_pkg::RESET_VECTOR;
         st_r.irq_bank <= 1'b0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Outputs straight from the state register
   assign PC_OUT       = st_r.pc;
   assign PUSH_OUT     = st_r.push;
   assign PUSH_PC_OUT  = st_r.push_pc;
   assign FLAGS_OUT    = st_r.flags;
   assign IRQ_BANK_OUT = st_r.irq_bank;
   assign CTRL_OUT     = st_r.ctrl;
endmodule

// >>> pkg/seq_pkg.sv
// Shared types and constants for the program sequencer and flag banks
package seq_pkg;
   localparam int PC_W = 13;
   localparam logic [12:0] RESET_VECTOR = 13'h0000;
   localparam logic [12:0] PC_STEP = 13'h0001;
   localparam int EXEC_MIN_CYC = 6;
   localparam int EXEC_MAX_CYC = 26;
   localparam int CYC_W = 5;
   localparam int GROUPS = 5;

   // Instruction decode groups
   typedef enum logic [2:0] {
      GRP_LOAD,
      GRP_ALU,
      GRP_JUMP,
      GRP_CTRL,
      GRP_FUZZY
   } group_e;

   // Flow events that steer the program counter and the flag bank
   typedef enum logic [2:0] {
      FLOW_NONE,
      FLOW_JUMP,
      FLOW_CALL,
      FLOW_IRQ,
      FLOW_RET,
      FLOW_RETURN_FROM_INTERRUPT
   } flow_e;

   typedef struct packed {
      logic carry;
      logic zero;
      logic sign;
   } flags_s;

   // Result of one arithmetic or logic operation
   typedef struct packed {
      logic valid;
      logic arith;
      logic overflow;
      logic underflow;
      logic is_zero;
   } alu_res_s;

   // Merged control bundle towards datapath and peripherals
   typedef struct packed {
      logic [GROUPS-1:0] group_onehot;
      logic              busy;
      logic              done;
   } ctrl_s;
endpackage

// >>> logic/group_arbiter.sv
// One-hot arbiter and execution timer for the decode groups
module group_arbiter #(
   parameter int GROUPS = seq_pkg::GROUPS
) (
   input  wire logic                      clk,
   input  wire logic                      arst_n,
   input  wire logic                      start,
   input  wire seq_pkg::group_e           group,
   input  wire logic [seq_pkg::CYC_W-1:0] cycles,
   output logic      [GROUPS-1:0]         active,
   output logic                           done
);
   typedef struct packed {
      logic [GROUPS-1:0]         active;
      logic [seq_pkg::CYC_W-1:0] left;
      logic                      done;
   } arb_s;

   arb_s st_r;
   arb_s st_nxt;

   initial begin
      if (GROUPS != 5) $error("group_arbiter serves five groups");
   end

   // Grant exactly one group, hold it for the instruction length
   always_comb begin
      st_nxt = st_r;
      st_nxt.done = 1'b0;
      if (st_r.active != '0) begin
         if (st_r.left <= 5'h01) begin
            st_nxt.active = '0;
            st_nxt.done = 1'b1;
         end else begin
            st_nxt.left = st_r.left - 5'h01;
         end
      end else if (start) begin
         st_nxt.active = '0;
         st_nxt.active[group] = 1'b1;
         if (cycles < 5'(seq_pkg::EXEC_MIN_CYC))
            st_nxt.left = 5'(seq_pkg::EXEC_MIN_CYC);
         else if (cycles > 5'(seq_pkg::EXEC_MAX_CYC))
            st_nxt.left = 5'(seq_pkg::EXEC_MAX_CYC);
         else
            st_nxt.left = cycles;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign active = st_r.active;
   assign done   = st_r.done;
endmodule

// >>> tb/seq_monitor.sv
// Port assertions for the sequencer and flag banks
module seq_monitor (
   input wire logic              SYS_CLK_IN,
   input wire logic              ARST_N_IN,
   input wire logic              FETCH_IN,
   input wire seq_pkg::flow_e    FLOW_IN,
   input wire logic       [12:0] TARGET_IN,
   input wire logic       [12:0] POP_PC_IN,
   input wire seq_pkg::alu_res_s ALU_RES_IN,
   input wire logic       [12:0] PC_OUT,
   input wire logic              PUSH_OUT,
   input wire logic       [12:0] PUSH_PC_OUT,
   input wire seq_pkg::flags_s   FLAGS_OUT,
   input wire logic              IRQ_BANK_OUT,
   input wire seq_pkg::ctrl_s    CTRL_OUT
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge SYS_CLK_IN); endclocking
   default disable iff (!ARST_N_IN);
   // Counter loads
   pc_step_a:
      assert property (FETCH_IN && FLOW_IN == seq_pkg::FLOW_NONE |=>
         PC_OUT == $past(PC_OUT) + 13'h1) else $error("pc step");
   jump_load_a:
      assert property (FLOW_IN == seq_pkg::FLOW_JUMP |=>
         PC_OUT == $past(TARGET_IN)) else $error("jump load");
   ret_load_a:
      assert property (FLOW_IN inside {seq_pkg::FLOW_RET,
         seq_pkg::FLOW_RETURN_FROM_INTERRUPT} |=> PC_OUT == $past(POP_PC_IN))
         else $error("return load");
   push_call_a:
      assert property (FLOW_IN inside {seq_pkg::FLOW_CALL,
         seq_pkg::FLOW_IRQ} |=> PUSH_OUT && IRQ_BANK_OUT &&
         PUSH_PC_OUT == $past(PC_OUT)) else $error("push on call");
   // Flag banks and arbiter
   bank_hold_a:
      assert property (FLOW_IN == seq_pkg::FLOW_NONE && !ALU_RES_IN.valid
         |=> $stable(FLAGS_OUT) && $stable(IRQ_BANK_OUT))
         else $error("flags moved");
   carry_sign_a:
      assert property (ALU_RES_IN.valid && ALU_RES_IN.arith &&
         FLOW_IN == seq_pkg::FLOW_NONE |=>
         FLAGS_OUT.carry == $past(ALU_RES_IN.overflow) &&
         FLAGS_OUT.sign == $past(ALU_RES_IN.underflow))
         else $error("carry or sign");
   zero_flag_a:
      assert property (ALU_RES_IN.valid && FLOW_IN == seq_pkg::FLOW_NONE
         |=> FLAGS_OUT.zero == $past(ALU_RES_IN.is_zero))
         else $error("zero flag");
   one_group_a:
      assert property ($onehot0(CTRL_OUT.group_onehot))
         else $error("two groups");
endmodule

// >>> tb/stack_model.sv
// Return address stack held in data memory
module stack_model (
   input  wire logic           clk,
   input  wire logic           arst_n,
   input  wire logic           push,
   input  wire logic    [12:0] push_pc,
   input  wire seq_pkg::flow_e flow,
   output logic         [12:0] pop_pc
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [12:0] mem [8];
   int          depth;
   // Empty stack shows the inverse, not a stale address
   assign pop_pc = (depth > 0) ? mem[depth-1] : ~push_pc;
   // Store on push, drop on return
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         depth <= 0;
      end else if (push) begin
         mem[depth] <= push_pc;
         depth <= depth + 1;
      end else if (flow inside {seq_pkg::FLOW_RET, seq_pkg::FLOW_RETURN_FROM_INTERRUPT} &&
                   depth > 0) begin
         depth <= depth - 1;
      end
   end
endmodule

// >>> tb/tb_top.sv
// Self-checking bench for the sequencer and flag banks
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin \
   error_cnt++; $display("wrong value %s exp %h got %h", n, e, a); end end
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic              clk = 1'b0;
   logic              rst_n = 1'b0;
   logic              fetch = 1'b0;
   logic              dv = 1'b0;
   seq_pkg::flow_e    fl = seq_pkg::FLOW_NONE;
   seq_pkg::group_e   grp = seq_pkg::GRP_LOAD;
   seq_pkg::alu_res_s alu = 5'h00;
   seq_pkg::flags_s   flg;
   seq_pkg::ctrl_s    ctrl;
   logic       [12:0] tgt = 13'h0000;
   logic       [12:0] pop;
   logic       [12:0] pc;
   logic       [12:0] ppc;
   logic        [4:0] ncyc = 5'h06;
   logic              push;
   logic              bank;
   int                error_cnt = 0;
   int                compares = 0;
   // Design and stack model
   pc_sequencer_flag_banks i_pc_sequencer_flag_banks (.SYS_CLK_IN(clk),
      .ARST_N_IN(rst_n), .FETCH_IN(fetch), .FLOW_IN(fl), .TARGET_IN(tgt),
      .POP_PC_IN(pop), .DECODE_VALID_IN(dv), .DECODE_GROUP_IN(grp),
      .DECODE_CYCLES_IN(ncyc), .ALU_RES_IN(alu), .PC_OUT(pc),
      .PUSH_OUT(push), .PUSH_PC_OUT(ppc), .FLAGS_OUT(flg),
      .IRQ_BANK_OUT(bank), .CTRL_OUT(ctrl));
   stack_model i_stack_model (.clk(clk), .arst_n(rst_n), .push(push),
      .push_pc(ppc), .flow(fl), .pop_pc(pop));
   always #25 clk = ~clk;
   // One request for one cycle, then idle
   task automatic op(seq_pkg::flow_e f, logic fe, logic [4:0] a,
                     logic [12:0] t);
      @(posedge clk);
      fl <= f;
      fetch <= fe;
      alu <= a;
      tgt <= t;
      @(posedge clk);
      fl <= seq_pkg::FLOW_NONE;
      fetch <= 1'b0;
      alu <= 5'h00;
      #1;
   endtask
   // Reset state, fetch, jump and wrap
   task automatic t_pc();
      `CHK("reset", 17'h0, {bank, flg, pc})
      repeat (3) op(seq_pkg::FLOW_NONE, 1'b1, 5'h00, 13'h0000);
      `CHK("fetch pc", 13'h0003, pc)
      op(seq_pkg::FLOW_JUMP, 1'b0, 5'h00, 13'h1fff);
      `CHK("jump pc", 13'h1fff, pc)
      op(seq_pkg::FLOW_NONE, 1'b1, 5'h00, 13'h0000);
      `CHK("wrap pc", 13'h0000, pc)
      op(seq_pkg::FLOW_JUMP, 1'b0, 5'h00, 13'h0003);
   endtask
   // Bank switching on call, return, irq and return_from_interrupt
   task automatic t_banks();
      op(seq_pkg::FLOW_NONE, 1'b0, 5'h1e, 13'h0000);
      `CHK("normal", 3'h5, flg)
      op(seq_pkg::FLOW_CALL, 1'b0, 5'h00, 13'h0100);
      `CHK("call", 27'h4006100, {push, ppc, pc})
      `CHK("irq bank", 4'h8, {bank, flg})
      op(seq_pkg::FLOW_NONE, 1'b0, 5'h11, 13'h0000);
      `CHK("irq zero", 4'ha, {bank, flg})
      op(seq_pkg::FLOW_RET, 1'b0, 5'h00, 13'h0000);
      `CHK("ret", 17'h0a003, {bank, flg, pc})
      op(seq_pkg::FLOW_IRQ, 1'b0, 5'h00, 13'h0020);
      `CHK("irq", 17'h14020, {bank, flg, pc})
      op(seq_pkg::FLOW_RETURN_FROM_INTERRUPT, 1'b0, 5'h00, 13'h0000);
      `CHK("return_from_interrupt", 17'h0a003, {bank, flg, pc})
   endtask
   // Each group alone for its length
   task automatic t_decode();
      int n;
      for (int g = 0; g < 5; g++) begin
         @(posedge clk);
         dv <= 1'b1;
         grp <= seq_pkg::group_e'(g);
         // Short request clamps up to 6, long one runs the full 26
         ncyc <= (g == 4) ? 5'h1a : ((g == 3) ? 5'h02 : 5'h06);
         @(posedge clk);
         dv <= 1'b0;
         n = 0;
         for (int w = 0; w < 40 && ctrl.group_onehot == 5'h00; w++)
            @(posedge clk) #1;
         while (ctrl.group_onehot != 5'h00 && n < 40) begin
            `CHK("group", 5'h01 << g, ctrl.group_onehot)
            n++;
            @(posedge clk) #1;
         end
         `CHK("length", (g == 4) ? 26 : 6, n)
         if (n == 0)
            summarize();
      end
   endtask
   task automatic summarize();
      $display("compares %0d error_cnt %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // Main sequence
   initial begin
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      #1;
      t_pc();
      t_banks();
      t_decode();
      summarize();
   end
endmodule
bind pc_sequencer_flag_banks seq_monitor i_seq_monitor (
   .SYS_CLK_IN(SYS_CLK_IN), .ARST_N_IN(ARST_N_IN), .FETCH_IN(FETCH_IN),
   .FLOW_IN(FLOW_IN), .TARGET_IN(TARGET_IN), .POP_PC_IN(POP_PC_IN),
   .ALU_RES_IN(ALU_RES_IN), .PC_OUT(PC_OUT), .PUSH_OUT(PUSH_OUT),
   .PUSH_PC_OUT(PUSH_PC_OUT), .FLAGS_OUT(FLAGS_OUT),
   .IRQ_BANK_OUT(IRQ_BANK_OUT), .CTRL_OUT(CTRL_OUT));
